// [hw/tdm_params.svh]
// constants of the serial tdm stream timing block
// assumes inclusion by bare name before the package and the modules
`ifndef TDM_PARAMS_SVH
`define TDM_PARAMS_SVH

// ****************************************************************
// lane geometry
// ****************************************************************
`define LANES 32
`define BUF_LANES 16
`define SYNC_W 67
`define CNT_W 12
`define IDX_W 11
`define CHAN_W 8
`define BYTE_W 8

// ****************************************************************
// mode register field positions
// ****************************************************************
`define MODE_W 16
`define MODE_BIDIR_UPPER_BIT 7
`define MODE_BIDIR_LOWER_BIT 6

// ****************************************************************
// rate codes and reset values
// ****************************************************************
`define BCLK_4M096 2'h0
`define BCLK_8M192 2'h1
`define BCLK_16M384 2'h2
`define RATE_2M048 2'h0
`define RATE_4M096 2'h1
`define RATE_8M192 2'h2
`define RATE_16M384 2'h3
`define RST_BYTE 8'h00
`define RST_CHAN 8'h00
`define RST_CNT 12'h000

// ****************************************************************
// accepted frame sync widths, informative
// ****************************************************************
`define FRAME_PULSE_SHORT_NS 61
`define FRAME_PULSE_MID_NS 122
`define FRAME_PULSE_LONG_NS 244

`endif

// [hw/tdm_pkg.sv]
// types of the serial tdm stream timing block
// assumes tdm_params.svh is on the include path
`include "tdm_params.svh"

package tdm_pkg;
  typedef logic [1:0] rate_t;
  typedef logic [`BYTE_W-1:0] byte_t;
  typedef logic [`CHAN_W-1:0] chan_t;
  typedef logic [`CNT_W-1:0] cnt_t;
  typedef struct packed {
    logic valid;
    chan_t chan;
    byte_t data;
  } rx_word_t;
endpackage

// [hw/lane_slot.sv]
// one lane: input deserialiser and output serialiser with slot control
// assumes tick, count and pins are already on ref_clk_in
`timescale 1ns/100ps
`default_nettype none
`include "tdm_params.svh"

module lane_slot (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire tdm_pkg::cnt_t cnt_in,
  input wire tdm_pkg::rate_t clk_code_in,
  input wire tdm_pkg::rate_t in_rate_in,
  input wire tdm_pkg::rate_t out_rate_in,
  input wire logic rx_pin_in,
  input wire logic drive_gate_in,
  input wire tdm_pkg::byte_t tx_byte_in,
  input wire logic tx_hiz_in,
  output tdm_pkg::rx_word_t rx_word_out,
  output tdm_pkg::chan_t tx_chan_out,
  output logic tx_bit_out,
  output logic tx_oe_n_out
);
  import tdm_pkg::*;

  // ****************************************************************
  // bit and channel position from the bit clock count
  // ****************************************************************
  wire logic [2:0] clk_p1 = {1'b0, clk_code_in} + 3'h1;
  wire logic in_ok = {1'b0, in_rate_in} <= clk_p1;
  wire logic out_ok = {1'b0, out_rate_in} <= clk_p1;
  // one bit clock cycle per bit at the top rate
  wire logic [2:0] in_shift = in_ok ? clk_p1 - {1'b0, in_rate_in} : 3'h0;
  wire logic [2:0] out_shift = out_ok ? clk_p1 - {1'b0, out_rate_in} : 3'h0;
  wire cnt_t in_mask = ~({`CNT_W{1'b1}} << in_shift);
  wire cnt_t out_mask = ~({`CNT_W{1'b1}} << out_shift);
  wire cnt_t in_full = cnt_in >> in_shift;
  wire cnt_t out_full = cnt_in >> out_shift;
  // 32, 64, 128 or 256 channels per frame
  wire chan_t in_chmask = {in_rate_in == `RATE_16M384,
    in_rate_in >= `RATE_8M192, in_rate_in >= `RATE_4M096, 5'h1f};
  wire chan_t out_chmask = {out_rate_in == `RATE_16M384,
    out_rate_in >= `RATE_8M192, out_rate_in >= `RATE_4M096, 5'h1f};
  // eight bits per slot, slots back to back
  wire chan_t in_chan = in_full[`IDX_W-1:3] & in_chmask;
  wire chan_t out_chan = out_full[`IDX_W-1:3] & out_chmask;
  wire logic in_last = tick_in && ((cnt_in & in_mask) == in_mask);
  wire logic out_first = tick_in && ((cnt_in & out_mask) == `RST_CNT);
  wire logic in_byte_end = in_last && (in_full[2:0] == 3'h7);
  wire logic out_load = out_first && (out_full[2:0] == 3'h0);

  // ****************************************************************
  // receive
  // ****************************************************************
  byte_t rx_sh_reg;
  wire byte_t rx_sh_next = {rx_sh_reg[6:0], rx_pin_in};

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rx_sh_reg <= `RST_BYTE;
      rx_word_out <= '0;
    end else begin
      if (in_last) begin
        rx_sh_reg <= rx_sh_next;
      end
      rx_word_out.valid <= in_byte_end;
      if (in_byte_end) begin
        rx_word_out.chan <= in_chan;
        rx_word_out.data <= rx_sh_next;
      end
    end
  end

  // ****************************************************************
  // transmit, msb first
  // ****************************************************************
  byte_t tx_sh_reg;
  logic hiz_reg;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      tx_sh_reg <= `RST_BYTE;
      tx_bit_out <= 1'b0;
      hiz_reg <= 1'b1;
      tx_chan_out <= `RST_CHAN;
    end else if (out_load) begin
      tx_sh_reg <= {tx_byte_in[6:0], 1'b0};
      tx_bit_out <= tx_byte_in[7];
      hiz_reg <= tx_hiz_in;
      tx_chan_out <= (out_chan + 8'h01) & out_chmask;
    end else if (out_first) begin
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      tx_bit_out <= tx_sh_reg[7];
    end
  end

  // floated slot or gate low floats the lane
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      tx_oe_n_out <= 1'b1;
    end else begin
      tx_oe_n_out <= !drive_gate_in || hiz_reg;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_rx_chan_range: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    rx_word_out.valid |-> (rx_word_out.chan & ~in_chmask) == 8'h00)
    else $error("receive channel beyond lane rate");

  chk_tx_chan_range: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    out_load |=> (tx_chan_out & ~$past(out_chmask)) == 8'h00)
    else $error("transmit channel beyond lane rate");

  chk_slot_float: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    out_load && drive_gate_in ##1 drive_gate_in [*2]
      |-> tx_oe_n_out == $past(tx_hiz_in, 2))
    else $error("lane float does not follow slot state");

  cov_rx_byte: cover property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) rx_word_out.valid);
  cov_hiz_slot: cover property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) out_load && tx_hiz_in);
endmodule
`default_nettype wire

// [hw/tdm_serial_stream_timing.sv]
// serial tdm stream timing: frame and bit clock front end, 32 lanes
// assumes config ports come from logic on ref_clk_in, pins are async
`timescale 1ns/100ps
`default_nettype none
`include "tdm_params.svh"

module tdm_serial_stream_timing (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic frame_sync_in,
  input wire logic bit_clock_in,
  input wire logic clock_loopback_sel_in,
  input wire logic frame_polarity_sel_in,
  input wire logic frame_format_sel_in,
  input wire logic clock_edge_sel_in,
  input wire tdm_pkg::rate_t bit_clock_rate_in,
  input wire logic [`MODE_W-1:0] internal_mode_in,
  input wire tdm_pkg::rate_t [`LANES-1:0] input_lane_ctrl_in,
  input wire tdm_pkg::rate_t [`LANES-1:0] output_lane_ctrl_in,
  input wire logic output_drive_gate_in,
  input wire logic [`LANES-1:0] serial_in_lanes_in,
  input wire logic [`LANES-1:0] serial_out_lanes_in,
  output logic [`LANES-1:0] serial_out_lanes_out,
  output logic [`LANES-1:0] serial_out_lanes_oe_n_out,
  output logic [`BUF_LANES-1:0] lane_buffer_float_ctl_out,
  input wire tdm_pkg::byte_t [`LANES-1:0] tx_byte_in,
  input wire logic [`LANES-1:0] tx_hiz_in,
  output tdm_pkg::chan_t [`LANES-1:0] tx_chan_out,
  output tdm_pkg::rx_word_t [`LANES-1:0] rx_word_out,
  output logic frame_boundary_out
);
  import tdm_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [`SYNC_W-1:0] sync1_reg;
  logic [`SYNC_W-1:0] sync2_reg;
  wire logic [`SYNC_W-1:0] pins_raw = {output_drive_gate_in, frame_sync_in,
    bit_clock_in, serial_out_lanes_in, serial_in_lanes_in};

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire logic [`LANES-1:0] in_pins_s = sync2_reg[`LANES-1:0];
  wire logic [`LANES-1:0] out_pins_s = sync2_reg[2*`LANES-1:`LANES];
  wire logic bclk_s = sync2_reg[2*`LANES];
  wire logic frame_s = sync2_reg[2*`LANES+1];
  wire logic gate_s = sync2_reg[2*`LANES+2];

  // ****************************************************************
  // bit clock edges and frame boundary
  // ****************************************************************
  logic bclk_prev_reg;
  logic frame_seen_reg;
  logic tick_reg;
  cnt_t cnt_reg;

  wire logic bclk_rise = bclk_s && !bclk_prev_reg;
  wire logic bclk_fall = !bclk_s && bclk_prev_reg;
  // selected edge; the loopback select masks every edge
  wire logic edge_hit = (clock_edge_sel_in ? bclk_rise : bclk_fall)
    && !clock_loopback_sel_in;
  // active low by default, inverted when exactly one of the two selects is set
  wire logic pol_eff = frame_polarity_sel_in ^ frame_format_sel_in;
  wire logic frame_act = pol_eff ? frame_s : !frame_s;
  // first edge with sync active, any accepted width
  wire logic boundary = edge_hit && frame_act && !frame_seen_reg;
  wire cnt_t cnt_next = boundary ? `RST_CNT : cnt_reg + 12'h001;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      bclk_prev_reg <= 1'b0;
      frame_seen_reg <= 1'b0;
      tick_reg <= 1'b0;
      cnt_reg <= `RST_CNT;
      frame_boundary_out <= 1'b0;
    end else begin
      bclk_prev_reg <= bclk_s;
      tick_reg <= edge_hit;
      frame_boundary_out <= boundary;
      if (edge_hit) begin
        frame_seen_reg <= frame_act;
        cnt_reg <= cnt_next;
      end
    end
  end

  // ****************************************************************
  // lanes
  // ****************************************************************
  wire logic bidir_upper_sel = internal_mode_in[`MODE_BIDIR_UPPER_BIT];
  wire logic bidir_lower_sel = internal_mode_in[`MODE_BIDIR_LOWER_BIT];
  // bidirectional lanes read the output pin, input pin ignored
  wire logic [`LANES-1:0] bidir_mask =
    {{`BUF_LANES{bidir_upper_sel}}, {`BUF_LANES{bidir_lower_sel}}};
  wire logic [`LANES-1:0] rx_src =
    (bidir_mask & out_pins_s) | (~bidir_mask & in_pins_s);
  // three codes only; a bad code behaves as the top rate
  wire rate_t clk_code = (bit_clock_rate_in > `BCLK_16M384) ?
    `BCLK_16M384 : bit_clock_rate_in;

  for (genvar i = 0; i < `LANES; i++) begin : g_lane
    lane_slot u_lane (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .tick_in(tick_reg),
      .cnt_in(cnt_reg),
      .clk_code_in(clk_code),
      .in_rate_in(input_lane_ctrl_in[i]),
      .out_rate_in(output_lane_ctrl_in[i]),
      .rx_pin_in(rx_src[i]),
      .drive_gate_in(gate_s),
      .tx_byte_in(tx_byte_in[i]),
      .tx_hiz_in(tx_hiz_in[i]),
      .rx_word_out(rx_word_out[i]),
      .tx_chan_out(tx_chan_out[i]),
      .tx_bit_out(serial_out_lanes_out[i]),
      .tx_oe_n_out(serial_out_lanes_oe_n_out[i])
    );
  end

  // buffer control mirrors the lane float, lanes 0 to 15
  assign lane_buffer_float_ctl_out =
    serial_out_lanes_oe_n_out[`BUF_LANES-1:0];

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_boundary_zero: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    boundary |=> tick_reg && cnt_reg == `RST_CNT && frame_boundary_out)
    else $error("boundary did not restart the count");

  chk_rise_edge: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    tick_reg && $past(clock_edge_sel_in)
      |-> $past(bclk_s) && !$past(bclk_s, 2))
    else $error("tick not on a rising bit clock edge");

  chk_fall_edge: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    tick_reg && !$past(clock_edge_sel_in)
      |-> !$past(bclk_s) && $past(bclk_s, 2))
    else $error("tick not on a falling bit clock edge");

  chk_frame_level: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    frame_boundary_out |-> $past(frame_s) == $past(pol_eff))
    else $error("boundary taken on the wrong sync level");

  chk_loop_quiet: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    clock_loopback_sel_in |=> !tick_reg)
    else $error("bit clock edge used in loopback");

  chk_gate_float: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    !gate_s |=> (&serial_out_lanes_oe_n_out)
      && (&lane_buffer_float_ctl_out))
    else $error("gate low left a lane or buffer driven");

  chk_single_boundary: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    edge_hit && frame_act |=> frame_seen_reg)
    else $error("one sync pulse gave two boundaries");

  cov_boundary: cover property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) frame_boundary_out);
  cov_bidir: cover property (@(posedge ref_clk_in)
    disable iff (!rst_n_in) frame_boundary_out && bidir_upper_sel);
endmodule
`default_nettype wire

// [dv/tdm_far_end.sv]
// far side model: bit clock, frame sync and one serial input stream
// assumes the bench chooses edge, active level and loopback hold
`timescale 1ns/100ps
`default_nettype none

module tdm_far_end #(
  parameter int FRAME = 256
) (
  input wire logic edge_sel_in,
  input wire logic active_lvl_in,
  input wire logic hold_in,
  output logic bclk_out,
  output logic fsync_out,
  output logic sdata_out
);
  // ****************************************************************
  // bit clock of 64 ns, two clock periods per 2.048 Mbps bit
  // ****************************************************************
  int pos = FRAME - 3;
  int nxt;

  // byte of channel ch is ch xor a5, msb first
  function automatic logic pat_bit(int p);
    logic [7:0] b;
    b = 8'(p >> 4) ^ 8'hA5;
    return b[7 - ((p >> 1) & 7)];
  endfunction

  initial begin
    bclk_out = 1'b1;
    fsync_out = 1'b1;
    sdata_out = 1'b0;
    #1;
    forever begin
      #32;
      if (!hold_in) begin
        bclk_out = ~bclk_out;
        nxt = (pos == FRAME - 1) ? 0 : pos + 1;
        if (bclk_out == edge_sel_in) begin
          pos = nxt;
        end else begin
          // one period wide pulse around the boundary edge
          fsync_out = (nxt == 0) ? active_lvl_in : ~active_lvl_in;
          sdata_out = pat_bit(nxt);
        end
      end
    end
  end
endmodule

`default_nettype wire

// [dv/test_tdm_serial_stream_timing.sv]
// self-checking bench of the serial tdm stream timing block
// assumes tdm_far_end drives bit clock, frame sync and serial input
`timescale 1ns/100ps
`default_nettype none
`include "tdm_params.svh"

module test_tdm_serial_stream_timing;
  import tdm_pkg::*;
  localparam int FR = 4096;
  logic ref_clk, rst_n, loop_sel, pol, fmt, edge_sel, gate;
  logic [15:0] mode;
  logic bclk, fsync, sdata, fb;
  logic [31:0] swire, sout, soe_n, hiz;
  logic [15:0] bufc;
  rate_t [31:0] irate, orate;
  byte_t [31:0] txb;
  chan_t [31:0] txc;
  rx_word_t [31:0] rxw;
  rx_word_t q31[$];
  logic [2:0] cfg [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  int n_mismatch = 0;
  int checked = 0;

  // ****************************************************************
  // design, far side and lane wires with pull-downs
  // ****************************************************************
  assign swire = sout & ~soe_n;
  tdm_serial_stream_timing i_tdm_serial_stream_timing (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .frame_sync_in(fsync),
    .bit_clock_in(bclk), .clock_loopback_sel_in(loop_sel),
    .frame_polarity_sel_in(pol), .frame_format_sel_in(fmt),
    .clock_edge_sel_in(edge_sel), .bit_clock_rate_in(2'h0),
    .internal_mode_in(mode), .input_lane_ctrl_in(irate),
    .output_lane_ctrl_in(orate), .output_drive_gate_in(gate),
    .serial_in_lanes_in({32{sdata}}), .serial_out_lanes_in(swire),
    .serial_out_lanes_out(sout), .serial_out_lanes_oe_n_out(soe_n),
    .lane_buffer_float_ctl_out(bufc), .tx_byte_in(txb), .tx_hiz_in(hiz),
    .tx_chan_out(txc), .rx_word_out(rxw), .frame_boundary_out(fb));
  tdm_far_end i_tdm_far_end (.edge_sel_in(edge_sel),
    .active_lvl_in(pol ^ fmt), .hold_in(loop_sel), .bclk_out(bclk),
    .fsync_out(fsync), .sdata_out(sdata));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // odd channels floated, even ones carry chan xor 3c
  always @(posedge ref_clk) begin
    for (int i = 0; i < 32; i++) begin
      txb[i] <= txc[i] ^ 8'h3C;
      hiz[i] <= txc[i][0];
    end
    if (rxw[31].valid === 1'b1) q31.push_back(rxw[31]);
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic fail_wait(string what);
    n_mismatch++;
    $display("[ERR] %s expected 1 seen 0", what);
    give_verdict();
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_fb(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (fb !== 1'b1 && n < 2 * FR);
    if (n >= 2 * FR) fail_wait("frame boundary");
  endtask

  task automatic get_rx(output rx_word_t w);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (rxw[0].valid !== 1'b1 && n < 400);
    if (n >= 400) fail_wait("rx word");
    w = rxw[0];
  endtask

  // 4.096 Mbps lane sees each 2.048 Mbps bit twice
  function automatic byte_t dbl(int c);
    byte_t b, r;
    b = 8'(c >> 1) ^ 8'hA5;
    for (int j = 0; j < 8; j++) r[7 - j] = b[7 - 4 * (c & 1) - j / 2];
    return r;
  endfunction

  initial begin
    int n;
    byte_t e;
    rx_word_t w;
    {rst_n, loop_sel, pol, fmt, edge_sel} = 5'h00;
    gate = 1'b1;
    mode = 16'h0000;
    irate = '0;
    irate[31] = 2'h1;
    orate = '0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    cmp("oe_n at reset", soe_n, 32'hFFFF_FFFF);
    cmp("buffer ctl at reset", bufc, 16'hFFFF);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      {pol, fmt, edge_sel} <= cfg[k];
      repeat (3) wait_fb(n);
      cmp("frame period", n, FR);
      q31.delete();
      for (int c = 0; c < 4; c++) begin
        get_rx(w);
        cmp("rx lane 0", {w.chan, w.data}, {8'(c), 8'(c) ^ 8'hA5});
      end
      for (int c = 0; c < 6; c++)
        cmp("rx lane 31", {q31[c].chan, q31[c].data}, {8'(c), dbl(c)});
    end
    // upper lanes read back their own output, lane 31 at the lane 0 rate
    @(posedge ref_clk);
    mode <= 16'h0080;
    irate[31] <= 2'h0;
    wait_fb(n);
    q31.delete();
    tick(272);
    for (int s = 1; s < 4; s++) begin
      e = 8'(s) ^ 8'h3C;
      for (int b = 0; b < 8; b++) begin
        if (s == 2) cmp("lane 0 bit", sout[0], e[7 - b]);
        cmp("buffer ctl", bufc, {16{s[0]}});
        cmp("upper oe_n", soe_n[31:16], {16{s[0]}});
        tick(32);
      end
    end
    // floated odd slots read back as the pull-down level
    for (int c = 1; c < 4; c++) begin
      e = (c % 2) ? 8'h00 : 8'(c) ^ 8'h3C;
      cmp("bidir lane 31", {q31[c].chan, q31[c].data}, {8'(c), e});
    end
    @(posedge ref_clk);
    gate <= 1'b0;
    tick(8);
    cmp("oe_n gated", soe_n, 32'hFFFF_FFFF);
    cmp("buffer ctl gated", bufc, 16'hFFFF);
    @(posedge ref_clk);
    gate <= 1'b1;
    loop_sel <= 1'b1;
    tick(8);
    n = 0;
    repeat (2 * FR) begin
      tick(1);
      if (fb === 1'b1) n++;
    end
    cmp("boundaries in loopback", n, 0);
    give_verdict();
  end
endmodule

`default_nettype wire
